// ===== design/dqs_pkg.sv
// types for the dual-quad serial front end
// assumes dqs_regs.svh holds the numeric constants
package dqs_pkg;
    typedef enum logic [3:0] {
        DQS_IDLE  = 4'b0001,
        DQS_INSTR = 4'b0010,
        DQS_RX    = 4'b0100,
        DQS_TX    = 4'b1000
    } dqs_state_t;
endpackage : dqs_pkg

// ===== design/dqs_regs.svh
// constants for the dual-quad serial front end
// assumes inclusion by bare name from design and testbench files
`ifndef DQS_REGS_SVH
`define DQS_REGS_SVH
`define DQS_LINES        8
`define DQS_INSTR_BITS   8
`define DQS_CYC_W        8
`define DQS_BIT_W        3
`define DQS_INSTR_LAST   3'h7
`define DQS_SYNC_RST     2'h0
`endif

// ===== design/dqs_spi_front.sv
// serial front end of a dual-quad flash: select, clock edges, capture, launch
// assumes host clock far slower than I_CLK_SYS (>= 8 system cycles per half)
`timescale 1ns/1ps
`default_nettype none
`include "dqs_regs.svh"
module dqs_spi_front (
    // system clock and reset
    input  wire logic                       I_CLK_SYS,
    input  wire logic                       I_NRST,
    // host pins, select active low
    input  wire logic                       I_SEL_HALF_A_N,
    input  wire logic                       I_SEL_HALF_B_N,
    input  wire logic                       I_SCLK_HALF_A,
    input  wire logic                       I_SCLK_HALF_B,
    input  wire logic [`DQS_LINES-1:0]      I_DATA_IN,
    output logic      [`DQS_LINES-1:0]      O_DATA_OUT,
    output logic      [`DQS_LINES-1:0]      O_DATA_OE,
    // command decoder side
    input  wire logic                       I_EMBED_BUSY,
    input  wire logic                       I_DDR_CMD,
    input  wire logic                       I_RD_CMD,
    input  wire logic [`DQS_CYC_W-1:0]      I_RD_CYC,
    input  wire logic [`DQS_LINES-1:0]      I_TX_DATA,
    output logic      [`DQS_INSTR_BITS-1:0] O_INSTR,
    output logic                            O_INSTR_VLD,
    output logic      [`DQS_LINES-1:0]      O_RX_DATA,
    output logic                            O_RX_VLD,
    output logic                            O_TX_TAKE,
    output logic      [`DQS_CYC_W-1:0]      O_CYC_CNT,
    // power state
    output logic                            O_ACTIVE,
    output logic                            O_STANDBY
);
    import dqs_pkg::*;

    logic [1:0]                 sel_n_s;
    logic [1:0]                 sck_s;
    logic                       sel_prev_q;
    logic                       sck_prev_q;
    logic                       armed_q;
    logic                       started_q;
    logic                       ddr_wait_q;
    logic                       ddr_q;
    logic [`DQS_BIT_W-1:0]      bit_cnt_q;
    logic [`DQS_CYC_W-1:0]      cyc_q;
    logic [`DQS_INSTR_BITS-1:0] instr_q;
    dqs_state_t                 state_q;
    dqs_state_t                 state_d;

    // both halves share one select and one clock from the host
    dqs_sync3 #(.W(2), .RST(`DQS_SYNC_RST)) u_sync_sel (
        .i_clk   (I_CLK_SYS),
        .i_nrst  (I_NRST),
        .i_async ({I_SEL_HALF_B_N, I_SEL_HALF_A_N}),
        .o_level (sel_n_s)
    );
    dqs_sync3 #(.W(2), .RST(`DQS_SYNC_RST)) u_sync_sck (
        .i_clk   (I_CLK_SYS),
        .i_nrst  (I_NRST),
        .i_async ({I_SCLK_HALF_B, I_SCLK_HALF_A}),
        .o_level (sck_s)
    );

    // a stray high on either select deselects the whole part
    wire sel       = ~(sel_n_s[0] | sel_n_s[1]);
    wire sck       = sck_s[0] & sck_s[1];
    // select synced with reset value "selected": a held-low select is
    // not mistaken for a fresh falling edge after reset
    wire sel_start = sel & ~sel_prev_q;
    wire sel_end   = ~sel & sel_prev_q;
    wire rise      = sel & ~sel_start & sck & ~sck_prev_q;
    wire fall      = sel & ~sel_start & ~sck & sck_prev_q;
    wire in_rx     = state_q == DQS_RX;
    wire in_tx     = state_q == DQS_TX;
    wire instr_end = state_q == DQS_INSTR && rise
                     && bit_cnt_q == `DQS_INSTR_LAST;
    // ddr capture waits for the fall that closes the last instruction bit
    wire rx_take   = in_rx && (rise || (fall && I_DDR_CMD && !ddr_wait_q));
    wire cyc_next  = fall && started_q;
    wire [`DQS_CYC_W-1:0] cyc_inc = cyc_q + `DQS_CYC_W'(1);
    wire tx_start  = in_rx && cyc_next && I_RD_CMD && cyc_inc == I_RD_CYC;
    wire tx_edge   = in_tx && (fall || (rise && ddr_q));
    wire launch    = tx_start || tx_edge;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            DQS_IDLE:  if (sel_start) state_d = DQS_INSTR;
            DQS_INSTR: if (instr_end) state_d = DQS_RX;
            DQS_RX:    if (tx_start) state_d = DQS_TX;
            DQS_TX:    state_d = DQS_TX;
        endcase
        if (!sel) begin
            state_d = DQS_IDLE;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            state_q    <= DQS_IDLE;
            sel_prev_q <= 1'b1;
            sck_prev_q <= 1'b0;
            armed_q    <= 1'b0;
        end else begin
            state_q    <= state_d;
            sel_prev_q <= sel;
            sck_prev_q <= sck;
            if (sel_start) begin
                armed_q <= 1'b1;
            end
        end
    end

    // cycle counter: mode 3 starts on the first fall, mode 0 at select
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST || sel_end) begin
            started_q <= 1'b0;
            cyc_q     <= '0;
        end else if (sel_start) begin
            started_q <= ~sck;
            cyc_q     <= '0;
        end else if (fall) begin
            started_q <= 1'b1;
            if (started_q) begin
                cyc_q <= cyc_inc;
            end
        end
    end

    // instruction shifter, line 0 only, rising edges only
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST || sel_end || sel_start) begin
            bit_cnt_q <= '0;
            instr_q   <= '0;
        end else if (state_q == DQS_INSTR && rise) begin
            bit_cnt_q <= bit_cnt_q + `DQS_BIT_W'(1);
            instr_q   <= {instr_q[`DQS_INSTR_BITS-2:0], I_DATA_IN[0]};
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST || sel_end) begin
            ddr_wait_q <= 1'b0;
            ddr_q      <= 1'b0;
        end else if (instr_end) begin
            ddr_wait_q <= 1'b1;
        end else if (in_rx && fall) begin
            ddr_wait_q <= 1'b0;
            ddr_q      <= I_DDR_CMD;
        end
    end

    // registered outputs toward the decoder
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            O_INSTR     <= '0;
            O_INSTR_VLD <= 1'b0;
            O_RX_DATA   <= '0;
            O_RX_VLD    <= 1'b0;
            O_CYC_CNT   <= '0;
        end else begin
            O_INSTR_VLD <= instr_end && armed_q;
            if (instr_end) begin
                O_INSTR <= {instr_q[`DQS_INSTR_BITS-2:0], I_DATA_IN[0]};
            end
            // all eight lines, line 0 lowest bit; decoder uses the nibble
            // for address phases and the full byte for data
            O_RX_VLD <= rx_take;
            if (rx_take) begin
                O_RX_DATA <= I_DATA_IN;
            end
            O_CYC_CNT <= sel_end ? '0 : cyc_q;
        end
    end

    // pad drive: released the cycle after deselect
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST || !sel) begin
            O_DATA_OUT <= '0;
            O_DATA_OE  <= '0;
            O_TX_TAKE  <= 1'b0;
        end else begin
            O_TX_TAKE <= launch;
            if (launch) begin
                O_DATA_OUT <= I_TX_DATA;
                O_DATA_OE  <= '1;
            end
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            O_ACTIVE  <= 1'b0;
            O_STANDBY <= 1'b1;
        end else begin
            O_ACTIVE  <= sel && armed_q;
            O_STANDBY <= !sel && !I_EMBED_BUSY;
        end
    end

    sequence s_deselect;
        sel_end;
    endsequence

    sequence s_dummy_done;
        tx_start;
    endsequence

    a_desel_hiz: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
        s_deselect |=> O_DATA_OE == '0 ##1 O_DATA_OE == '0)
        else $error("pads driven while deselected");

    a_standby_power: assert property (@(posedge I_CLK_SYS)
        disable iff (!I_NRST)
        (!sel && !I_EMBED_BUSY) ##1 (!sel && !I_EMBED_BUSY)
        |=> O_STANDBY && !O_ACTIVE)
        else $error("no standby while idle");

    a_active_power: assert property (@(posedge I_CLK_SYS)
        disable iff (!I_NRST)
        sel_start |=> ##1 O_ACTIVE && !O_STANDBY)
        else $error("select did not enter active state");

    a_arm_first: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
        O_INSTR_VLD |-> $past(armed_q))
        else $error("command before first select edge");

    a_instr_rise: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
        O_INSTR_VLD |-> $past(rise) && $past(bit_cnt_q) == `DQS_INSTR_LAST)
        else $error("instruction completed off a rising edge");

    a_ddr_first_addr: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_NRST)
        in_rx && fall && ddr_wait_q |=> !O_RX_VLD)
        else $error("address captured on closing fall");

    a_rx_rise: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_NRST)
        in_rx && rise |=> O_RX_VLD && O_RX_DATA == $past(I_DATA_IN))
        else $error("rising edge not captured");

    a_cycle_count: assert property (@(posedge I_CLK_SYS)
        disable iff (!I_NRST)
        cyc_next && !sel_end |=> cyc_q == $past(cyc_q) + `DQS_CYC_W'(1))
        else $error("cycle not counted on falling edge");

    a_tx_first: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
        s_dummy_done |=> O_TX_TAKE && O_DATA_OE == '1
        && O_DATA_OUT == $past(I_TX_DATA))
        else $error("first read byte not launched");

    a_sel_discard: assert property (@(posedge I_CLK_SYS)
        disable iff (!I_NRST)
        s_deselect |=> state_q == DQS_IDLE && bit_cnt_q == '0
        && cyc_q == '0)
        else $error("partial command survived deselect");
endmodule : dqs_spi_front
`default_nettype wire

// ===== design/dqs_sync3.sv
// three-stage synchroniser, output moves when stages two and three agree
// assumes a single system clock and synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module dqs_sync3 #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    // asynchronous level in, settled level out
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            s1_q  <= RST;
            s2_q  <= RST;
            s3_q  <= RST;
            out_q <= RST;
        end else begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int b = 0; b < W; b++) begin
                if (s2_q[b] == s3_q[b]) begin
                    out_q[b] <= s3_q[b];
                end
            end
        end
    end

    assign o_level = out_q;
endmodule : dqs_sync3
`default_nettype wire

// ===== testbench/dqs_host_model.sv
// spi host model: one select and one clock fanned out to both halves
// assumes i_clk paces it; an sclk half period is ten i_clk cycles
`timescale 1ns/1ps
`default_nettype none
module dqs_host_model (
    // pacing clock
    input  wire logic       i_clk,
    // host pins
    output logic            o_sel_n,
    output logic            o_sclk,
    output logic      [7:0] o_data
);
    logic mode3;
    initial begin
        mode3   = 1'b0;
        o_sel_n = 1'b1;
        o_sclk  = 1'b0;
        o_data  = 8'h00;
    end
    task automatic w(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : w
    // data leads the edge by 3 cycles, held 7 so the raw sample sees it
    task automatic edg(input logic v, input logic [7:0] d);
        o_data = d;
        w(3);
        o_sclk = v;
        w(7);
    endtask : edg
    // clock parks at its polarity before select falls
    task automatic start(input logic m3);
        mode3  = m3;
        o_sclk = m3;
        w(10);
        o_sel_n = 1'b0;
        w(10);
        if (mode3) edg(1'b0, o_data);
    endtask : start
    // instruction msb first on lines 0 and 4 alike
    task automatic instr(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            edg(1'b1, {3'h0, b[i], 3'h0, b[i]});
            edg(1'b0, 8'h00);
        end
    endtask : instr
    // released lines show the inverse, except after a closing edge, whose inverse is undone so the last value stays
    task automatic stop();
        if (o_sclk !== mode3) edg(mode3, ~o_data);
        o_sel_n = 1'b1;
        o_data  = ~o_data;
        w(10);
    endtask : stop
endmodule : dqs_host_model
`default_nettype wire

// ===== testbench/test_dual_quad_spi_flash_signal_protocol.sv
// bench for the dual-quad serial front end, host model on the pins
// assumes design/dqs_regs.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "dqs_regs.svh"
module test_dual_quad_spi_flash_signal_protocol;
    logic                        clk, nrst, busy, ddr, rd;
    logic [`DQS_CYC_W-1:0]       rd_cyc, cyc_cnt;
    logic [`DQS_LINES-1:0]       tx_data, dout, doe, rx_data, bus;
    logic [`DQS_INSTR_BITS-1:0]  instr;
    logic                        instr_vld, rx_vld, tx_take;
    logic                        active, standby, sel_n, sclk;
    logic [7:0]                  hdata;
    int failures, num_checks, rx_n, take_n, ins_n, ticks;
    initial clk = 1'b0;
    always #4 clk = ~clk;
    assign tx_data = 8'hC3 ^ 8'(take_n);
    assign bus     = (doe & dout) | (~doe & hdata);
    dqs_host_model host (.i_clk(clk), .o_sel_n(sel_n), .o_sclk(sclk),
                         .o_data(hdata));
    dqs_spi_front DUT (
        .I_CLK_SYS(clk), .I_NRST(nrst),
        .I_SEL_HALF_A_N(sel_n), .I_SEL_HALF_B_N(sel_n),
        .I_SCLK_HALF_A(sclk), .I_SCLK_HALF_B(sclk),
        .I_DATA_IN(bus), .O_DATA_OUT(dout), .O_DATA_OE(doe),
        .I_EMBED_BUSY(busy), .I_DDR_CMD(ddr), .I_RD_CMD(rd),
        .I_RD_CYC(rd_cyc), .I_TX_DATA(tx_data), .O_INSTR(instr),
        .O_INSTR_VLD(instr_vld), .O_RX_DATA(rx_data), .O_RX_VLD(rx_vld),
        .O_TX_TAKE(tx_take), .O_CYC_CNT(cyc_cnt), .O_ACTIVE(active),
        .O_STANDBY(standby));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string msg);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    // ceiling well above the few thousand cycles the run needs
    always @(posedge clk) begin
        ticks <= ticks + 1;
        if (rx_vld === 1'b1) rx_n <= rx_n + 1;
        if (tx_take === 1'b1) take_n <= take_n + 1;
        if (instr_vld === 1'b1) ins_n <= ins_n + 1;
        if (ticks == 20000) begin
            failures++;
            finish_test();
        end
    end
    task automatic t_idle();
        check(standby, 1'b1, "standby at rest");
        check(active, 1'b0, "active at rest");
        for (int i = 0; i < 8; i++) begin
            host.edg(1'b1, 8'hFF);
            host.edg(1'b0, 8'hFF);
        end
        check(8'(ins_n + rx_n), 8'h00, "deselected pins seen");
        check(doe, 8'h00, "lines driven while deselected");
        busy = 1'b1;
        host.w(4);
        check(standby, 1'b0, "standby while busy");
        busy = 1'b0;
        host.w(4);
    endtask : t_idle
    // select already low when reset lifts is no falling edge
    task automatic t_nofall();
        int i;
        host.start(1'b0);
        nrst = 1'b0;
        host.w(20);
        nrst = 1'b1;
        host.w(4);
        i = ins_n;
        host.instr(8'hA5);
        check(8'(ins_n - i), 8'h00, "command without select fall");
        host.stop();
    endtask : t_nofall
    task automatic t_sdr_write(input logic m3);
        int r;
        int n;
        ddr = 1'b0;
        rd  = 1'b0;
        host.start(m3);
        check(active, 1'b1, "not active when selected");
        r = rx_n;
        n = ins_n;
        host.instr(8'hA5);
        check(8'(ins_n - n), 8'h01, "instruction not flagged");
        check(instr, 8'hA5, "instruction");
        check(cyc_cnt, 8'h08, "cycles after instruction");
        host.edg(1'b1, 8'h5A);
        check(rx_data, 8'h5A, "byte on eight lines");
        host.edg(1'b0, 8'h00);
        check(8'(rx_n - r), 8'h01, "sdr captures per cycle");
        check(cyc_cnt, 8'h09, "cycle count");
        host.stop();
    endtask : t_sdr_write
    task automatic t_abort();
        host.start(1'b0);
        for (int i = 0; i < 3; i++) begin
            host.edg(1'b1, 8'h11);
            host.edg(1'b0, 8'h00);
        end
        host.stop();
        check(cyc_cnt, 8'h00, "count kept over deselect");
        host.start(1'b0);
        host.instr(8'h3C);
        check(instr, 8'h3C, "partial command not discarded");
        check(cyc_cnt, 8'h08, "count not cleared");
        host.stop();
    endtask : t_abort
    task automatic t_read(input logic m3, input logic dd,
                          input logic [7:0] lat);
        int r;
        int t;
        ddr    = dd;
        rd     = 1'b1;
        rd_cyc = lat;
        host.start(m3);
        r = rx_n;
        t = take_n;
        host.instr(8'h6B);
        check(8'(rx_n - r), 8'h00, "capture in instruction");
        host.edg(1'b1, 8'h77); // nibble repeated on both halves
        check(rx_data, 8'h77, "first address edge");
        host.edg(1'b0, 8'h22);
        check(8'(rx_n - r), {7'h0, dd} + 8'h01, "fall capture");
        // dummy cycles ahead of the last one stay undriven
        for (int i = 10; i < lat; i++) begin
            host.edg(1'b1, 8'h33);
            host.edg(1'b0, 8'hCC);
            check(doe, 8'h00, "drive in early dummy");
        end
        host.edg(1'b1, 8'h33);
        check(doe, 8'h00, "drive before last dummy");
        host.edg(1'b0, 8'hCC);
        check(doe, 8'hFF, "no drive at last dummy");
        check(dout, 8'hC3 ^ 8'(t), "first byte");
        host.edg(1'b1, 8'h33);
        check(dout, 8'hC3 ^ 8'(t + dd), "rise launch");
        host.edg(1'b0, 8'hCC);
        check(8'(take_n - t), {7'h0, dd} + 8'h02, "bytes taken");
        host.stop();
        check(doe, 8'h00, "drive after deselect");
        check(standby, 1'b1, "standby after deselect");
    endtask : t_read
    initial begin
        nrst   = 1'b0;
        busy   = 1'b0;
        ddr    = 1'b0;
        rd     = 1'b0;
        rd_cyc = 8'h0A;
        repeat (20) @(posedge clk);
        #1;
        nrst = 1'b1;
        host.w(8);
        t_idle();
        host.start(1'b0);
        host.stop();
        t_sdr_write(1'b0);
        t_sdr_write(1'b1);
        t_abort();
        t_read(1'b0, 1'b0, 8'h0A);
        t_read(1'b1, 1'b0, 8'h0B);
        t_read(1'b0, 1'b1, 8'h0B);
        t_read(1'b1, 1'b1, 8'h0A);
        t_nofall();
        finish_test();
    end
endmodule : test_dual_quad_spi_flash_signal_protocol
`default_nettype wire
